// file: design/owd_pkg.sv
package owd_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [15:0] CFG_IDX = 16'h001f;
  localparam logic [15:0] SVC_IDX = 16'hffff;
  localparam logic [15:0] CAUSE_IDX = 16'h0020;
  localparam logic [15:0] STAT_IDX = 16'h0021;
  localparam int unsigned ADDR_W = 18;

  // Value after reset, and the mask of writable bits.
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'hbf;

  // Cycle counts, all in oscillator clock cycles.
  localparam int unsigned RST_PULSE_CYC = 32;
  localparam int unsigned POR_CLR_CYC = 4096;

  // Timeout exponents: the period is 2^hi minus 2^low cycles.
  localparam int unsigned TOT_W = 18;
  localparam int unsigned SLOW_EXP = 18;
  localparam int unsigned FAST_EXP = 13;
  localparam int unsigned LOW_EXP = 4;
  localparam int unsigned SVC_LOW_BIT = 4;

  // Configuration register one, bit 7 down to bit 0.
  typedef struct packed {
    logic lv_in_stop;
    logic rsvd;
    logic lv_rst_off;
    logic lv_pwr_off;
    logic short_stop_rec;
    logic timeout_rate_select;
    logic stop_enable;
    logic watchdog_disable;
  } owd_cfg_s;

  // Filtered test high voltage levels.
  typedef struct packed {
    logic on_irq;
    logic on_rst;
  } owd_hv_s;

  // Reset pulse sequencer.
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } owd_state_e;

  // Last combined count before overflow for the chosen rate.
  function automatic logic [TOT_W-1:0] owd_last(input logic slow);
    logic [TOT_W:0] lim;
    lim = slow ? (19'h1 << SLOW_EXP) : (19'h1 << FAST_EXP);
    lim = lim - (19'h1 << LOW_EXP) - 19'h1;
    return lim[TOT_W-1:0];
  endfunction

endpackage

// file: design/owd_top.sv
// How it works
// - 12-bit prescaler feeds free-running 6-bit counter.
// - Rate bit picks long or short timeout.
// - Unserviced overflow issues a system reset.
// - Service write clears counter and upper prescaler.
// - Service address reads back reset vector low.
// - Reset pin low 32 cycles, cause bit set.
// - Stop instruction clears whole prescaler.
// - Prescaler cleared 4096 cycles after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Configuration bit 0 disables the watchdog.
// - High-voltage monitor entry disables while voltage stays.
// - Blank-vector monitor entry disables until power-on.
// - Break with high voltage on reset disables.
// - Counting continues during wait mode.
// - Stop mode freezes prescaler and counter.
// - Stop disabled: stop causes illegal-opcode reset.
// - No interrupt request, only reset.
//
// The Avalon-MM register port is this design's own decision.
module owd_top
  import owd_pkg::*;
#(
  parameter int unsigned PRE_W = 12,
  parameter int unsigned CNT_W = 6
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] reset_vector_low,
  input wire logic stop_exec,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic reset_vector_fetch,
  input wire logic internal_reset,
  input wire logic monitor_entry,
  input wire logic break_active,
  input wire logic test_hv_irq_pin,
  input wire logic test_hv_rst_pin,
  output logic stop_grant,
  output logic illegal_op_reset,
  output logic wd_reset_req,
  output logic rst_pin_o,
  output logic rst_pin_oe
);

  // The timeout formula only fits an 18-bit combined count.
  if (PRE_W + CNT_W != TOT_W || PRE_W <= SVC_LOW_BIT) begin : g_bad_width
    $error("owd_top: prescaler and counter widths must total 18 bits");
  end

  owd_cfg_s cfg_r; // Configuration register one.
  owd_state_e state_r; // Reset pulse sequencer state.
  logic [PRE_W-1:0] pre_r; // Prescaler.
  logic [CNT_W-1:0] cnt_r; // Timeout counter.
  logic [5:0] pulse_r; // Reset pin low-time counter.
  logic [12:0] por_r; // Cycles since power-up.
  logic por_done_r; // Power-up clear already given.
  logic cause_r; // Watchdog reset cause flag.
  logic ack_r; // Bus answer phase.
  logic [31:0] rdata_r; // Read data holding register.
  logic [2:0] hv_irq_s; // Pin synchroniser for irq voltage.
  logic [2:0] hv_rst_s; // Pin synchroniser for reset voltage.
  owd_hv_s hv_r; // Filtered voltage levels.
  logic mon_hv_r; // Monitor entered with voltage on irq pin.
  logic mon_blank_r; // Monitor entered from blank vectors.
  logic illegal_r; // Registered illegal-opcode reset.
  logic grant_r; // Registered stop grant.
  logic ovf_r; // Registered overflow pulse.

  logic [15:0] idx; // Word index of the current access.
  logic wr_go; // Write taking effect this edge.
  logic svc_wr; // Service write taking effect.
  logic por_clr; // Power-up prescaler clear pulse.
  logic full_clr; // Clears prescaler and counter.
  logic pre_clr; // Clears the whole prescaler only.
  logic run; // Oscillator clock reaches the watchdog.
  logic wd_off; // Watchdog disabled by any cause.
  logic ovf; // Overflow event this cycle.

  // Bus decode. The access is answered one cycle after it appears.
  assign idx = avs_address[ADDR_W-1:2];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r & avs_byteenable[0];
  assign svc_wr = wr_go && idx == SVC_IDX;

  // Answer toggles so that each access waits exactly one cycle.
  // A master that holds its request after the answer starts a fresh access,
  // so every transfer costs two cycles and never more.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // Read data is captured in the waiting cycle, so it stands at the answer.
  // It then holds until the next read, which keeps the bus output a flip-flop.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_r <= 32'h0;
    end else if (avs_read && !ack_r) begin
      unique case (idx)
        CFG_IDX: rdata_r <= {24'h0, cfg_r & CFG_WMASK};
        // The service location is the vector byte, not watchdog state.
        SVC_IDX: rdata_r <= {24'h0, reset_vector_low};
        CAUSE_IDX: rdata_r <= {31'h0, cause_r};
        STAT_IDX: rdata_r <= {16'h0, 2'h0, cnt_r, 7'h0, wd_off};
        default: rdata_r <= 32'h0;
      endcase
    end
  end
  assign avs_readdata = rdata_r;

  // Configuration writes. The reserved bit stays zero.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_r <= CFG_RST;
    end else if (wr_go && idx == CFG_IDX) begin
      cfg_r <= avs_writedata[7:0] & CFG_WMASK;
    end
  end

  // Pin synchronisers: three stages, a change counts when two agree.
  // The filter costs four cycles of latency, which is harmless for a level
  // that only changes when a test fixture is applied or removed.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hv_irq_s <= 3'h0;
      hv_rst_s <= 3'h0;
      hv_r <= '0;
    end else begin
      hv_irq_s <= {hv_irq_s[1:0], test_hv_irq_pin};
      hv_rst_s <= {hv_rst_s[1:0], test_hv_rst_pin};
      if (hv_irq_s[1] == hv_irq_s[2]) begin
        hv_r.on_irq <= hv_irq_s[2];
      end
      if (hv_rst_s[1] == hv_rst_s[2]) begin
        hv_r.on_rst <= hv_rst_s[2];
      end
    end
  end

  // Monitor-mode disables. The blank-vector one is only released by
  // power-on reset, so an internal reset does not touch it.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mon_hv_r <= 1'b0;
      mon_blank_r <= 1'b0;
    end else begin
      if (monitor_entry && hv_r.on_irq) begin
        mon_hv_r <= 1'b1;
      end else if (!hv_r.on_irq && !hv_r.on_rst) begin
        mon_hv_r <= 1'b0;
      end
      if (monitor_entry && !hv_r.on_irq) begin
        mon_blank_r <= 1'b1;
      end
    end
  end

  // Every disabling cause. Break needs voltage on the reset pin.
  // The break path needs no latch, since it follows the filtered level directly.
  assign wd_off = cfg_r.watchdog_disable
                | mon_hv_r | mon_blank_r
                | (break_active & hv_r.on_rst);

  // Power-up timer gives one prescaler clear after 4096 cycles.
  // The timer stops once it has fired, so a long run never repeats the clear.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      por_r <= 13'h0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_r <= por_r + 13'h1;
      if (por_r == 13'(POR_CLR_CYC - 1)) begin
        por_done_r <= 1'b1;
      end
    end
  end
  assign por_clr = !por_done_r && por_r == 13'(POR_CLR_CYC - 1);

  // Our own overflow is an internal reset as well.
  // Treating it this way restarts a full period after each bite.
  assign full_clr = internal_reset | ovf_r;
  assign pre_clr = stop_exec | reset_vector_fetch | por_clr;

  // Wait mode does not gate the clock; only stop mode does.
  // The gating is done as a hold, since a gated clock would need its own tree.
  assign run = !stop_mode;

  // Overflow is held off while disabled or while a pulse is running.
  // Matching one exact count keeps both rates on the same adder chain.
  assign ovf = run && !wd_off && state_r == ST_RUN && !full_clr
             && !pre_clr && !svc_wr
             && {cnt_r, pre_r} == owd_last(cfg_r.timeout_rate_select);

  // Prescaler and counter. Clears outrank service, which outranks counting.
  // A stop clears the whole prescaler but leaves the counter, so software
  // should service around stop to get a full period back.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pre_r <= '0;
      cnt_r <= '0;
    end else if (full_clr) begin
      pre_r <= '0;
      cnt_r <= '0;
    end else begin
      if (pre_clr) begin
        pre_r <= '0;
      end else if (svc_wr) begin
        // Low four stages keep their count, not cleared, so service timing stays smooth.
        pre_r <= {{(PRE_W-SVC_LOW_BIT){1'b0}}, pre_r[SVC_LOW_BIT-1:0]};
      end else if (run) begin
        pre_r <= pre_r + 1'b1;
      end
      if (svc_wr) begin
        cnt_r <= '0;
      end else if (run && !pre_clr && &pre_r) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Reset pulse sequencer drives the pin low for 32 cycles.
  // The pulse length is fixed, and a new overflow cannot start while it runs.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= ST_RUN;
      pulse_r <= 6'h0;
    end else begin
      unique case (state_r)
        ST_RUN: begin
          pulse_r <= 6'h0;
          if (ovf) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          pulse_r <= pulse_r + 6'h1;
          if (pulse_r == 6'(RST_PULSE_CYC - 1)) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Open-drain reset pin: only ever pulled low.
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = state_r == ST_HOLD;

  // Cause flag: hardware set wins over a software clear in the same cycle.
  // Software learns the cause after the restart by reading this flag.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cause_r <= 1'b0;
    end else if (ovf_r) begin
      cause_r <= 1'b1;
    end else if (wr_go && idx == CAUSE_IDX && avs_writedata[0]) begin
      cause_r <= 1'b0;
    end
  end

  // Registered event outputs. There is no interrupt output at all.
  // Every output here comes from a flip-flop, wd_reset_req as a one-cycle pulse, so a consumer
  // in another block sees a clean level with no combinational glitch.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ovf_r <= 1'b0;
      illegal_r <= 1'b0;
      grant_r <= 1'b0;
    end else begin
      ovf_r <= ovf;
      illegal_r <= stop_exec & ~cfg_r.stop_enable;
      grant_r <= stop_exec & cfg_r.stop_enable;
    end
  end
  assign wd_reset_req = ovf_r;
  assign illegal_op_reset = illegal_r;
  assign stop_grant = grant_r;

  // Helper: no clear or service this cycle.
  logic quiet;
  assign quiet = !full_clr && !pre_clr && !svc_wr;

  // Checks. One clock and one reset serve all of them, as there is one domain.
  AST_PIN_LOW_32: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(rst_pin_oe) |-> ##31 rst_pin_oe ##1 !rst_pin_oe)
    else $error("reset pin low time is not 32 cycles");

  AST_CAUSE_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
    wd_reset_req |=> cause_r && rst_pin_oe)
    else $error("watchdog reset did not set cause and pin");

  AST_TIMEOUT_POINT: assert property (@(posedge ref_clk) disable iff (!rstn)
    wd_reset_req |-> $past({cnt_r, pre_r}) == owd_last($past(cfg_r.timeout_rate_select)))
    else $error("overflow at wrong count");

  AST_SERVICE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (svc_wr && !full_clr && !pre_clr) |=> cnt_r == '0
      && pre_r[PRE_W-1:SVC_LOW_BIT] == '0
      && pre_r[SVC_LOW_BIT-1:0] == $past(pre_r[SVC_LOW_BIT-1:0]))
    else $error("service write did not clear the right stages");

  AST_SVC_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
    (avs_read && !avs_waitrequest && idx == SVC_IDX)
      |-> avs_readdata == {24'h0, $past(reset_vector_low)})
    else $error("service read did not return vector byte");

  AST_FULL_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
    internal_reset |=> pre_r == '0 && cnt_r == '0)
    else $error("internal reset did not clear counters");

  AST_PRE_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (reset_vector_fetch || stop_exec) |=> pre_r == '0)
    else $error("prescaler not cleared");

  AST_STOP_FREEZE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (stop_mode && quiet) |=> $stable(pre_r) && $stable(cnt_r))
    else $error("watchdog advanced in stop mode");

  AST_OFF_NO_RESET: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(wd_off) |-> !wd_reset_req)
    else $error("disabled watchdog issued a reset");

  AST_BLANK_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
    mon_blank_r |=> mon_blank_r && wd_off)
    else $error("blank-vector disable released");

  AST_ILLEGAL: assert property (@(posedge ref_clk) disable iff (!rstn)
    (stop_exec && !cfg_r.stop_enable) |=> illegal_op_reset && !stop_grant)
    else $error("disabled stop did not give illegal-opcode reset");

  AST_POR_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
    por_clr |=> pre_r == '0 && por_done_r)
    else $error("power-up prescaler clear missing");

  AST_WAIT_COUNT: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wait_mode && run && quiet) |=> pre_r == $past(pre_r) + 1'b1)
    else $error("prescaler stalled in wait mode");

  AST_CARRY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (run && quiet && &pre_r) |=> cnt_r == $past(cnt_r) + 1'b1 && pre_r == '0)
    else $error("prescaler carry did not advance the counter");

  AST_HV_RELEASE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!monitor_entry && !hv_r.on_irq && !hv_r.on_rst) |=> !mon_hv_r)
    else $error("voltage-held disable did not release");

  AST_GRANT: assert property (@(posedge ref_clk) disable iff (!rstn)
    (stop_exec && cfg_r.stop_enable) |=> stop_grant && !illegal_op_reset)
    else $error("allowed stop was not granted");

  AST_BREAK_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
    (break_active && hv_r.on_rst) |-> wd_off)
    else $error("break with test voltage left the watchdog on");

  COV_WD_RESET: cover property (@(posedge ref_clk) disable iff (!rstn) wd_reset_req);
  COV_SERVICE: cover property (@(posedge ref_clk) disable iff (!rstn) svc_wr);
  COV_ILLEGAL: cover property (@(posedge ref_clk) disable iff (!rstn) illegal_op_reset);
  COV_MON_OFF: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(mon_hv_r));
  COV_WAIT_BITE: cover property (@(posedge ref_clk) disable iff (!rstn) wait_mode && wd_reset_req);

endmodule

// file: testbench/owd_cpu_model.sv
// Behavioural stand-in for the CPU core and the system reset logic.
module owd_cpu_model
  import owd_pkg::*;
#(
  // Reset vector low byte held in memory; the value is arbitrary.
  parameter logic [7:0] VEC_LOW = 8'h5a
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic rst_pin_oe,
  output logic internal_reset,
  output logic reset_vector_fetch,
  output logic [7:0] reset_vector_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // Last seen level of the reset pin pull-down.
  logic pin_q_r;

  // Memory always presents the same vector byte at the shared address.
  assign reset_vector_low = VEC_LOW;

  // When the pin is let go, the reset logic issues an internal reset and the CPU then fetches the vector.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_q_r <= 1'b0;
      internal_reset <= 1'b0;
      reset_vector_fetch <= 1'b0;
    end else begin
      pin_q_r <= rst_pin_oe;
      internal_reset <= pin_q_r & ~rst_pin_oe;
      reset_vector_fetch <= internal_reset;
    end
  end
endmodule

// file: testbench/operating_watchdog_bench.sv
module operating_watchdog_bench
  import owd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [ADDR_W-1:0] A_CFG = {CFG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_SVC = {SVC_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_CAU = {CAUSE_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_STA = {STAT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_BAD = 18'h00088;
  localparam logic [7:0] VEC = 8'h5a;
  localparam int QUIET = 8400;

  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] vec_low;
  logic stop_exec = 1'b0;
  logic stop_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic monitor_entry = 1'b0;
  logic break_active = 1'b0;
  logic hv_irq = 1'b0;
  logic hv_rst = 1'b0;
  logic rv_fetch, int_rst, stop_grant, illegal_op_reset, wd_reset_req, rst_pin_o, rst_pin_oe;
  logic [1:0] o;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int at, pin;

  owd_top u_owd_top (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .reset_vector_low(vec_low),
    .stop_exec(stop_exec), .stop_mode(stop_mode), .wait_mode(wait_mode), .reset_vector_fetch(rv_fetch),
    .internal_reset(int_rst), .monitor_entry(monitor_entry), .break_active(break_active),
    .test_hv_irq_pin(hv_irq), .test_hv_rst_pin(hv_rst), .stop_grant(stop_grant),
    .illegal_op_reset(illegal_op_reset), .wd_reset_req(wd_reset_req), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe));

  owd_cpu_model #(.VEC_LOW(VEC)) u_owd_cpu_model (.ref_clk(ref_clk), .rstn(rstn), .rst_pin_oe(rst_pin_oe),
    .internal_reset(int_rst), .reset_vector_fetch(rv_fetch), .reset_vector_low(vec_low));

  // Free-running 50 MHz oscillator clock.
  always #10 ref_clk = ~ref_clk;

  // Cuts a hang short; the planned sequence needs about 90000 cycles.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_errors++;
      $display("Error at %0t: run did not finish in time", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon access; waitrequest and read data are both taken at the answering edge.
  task automatic bus(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [31:0] q);
    logic w;
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_read <= rd;
    avs_write <= ~rd;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= 4'h1;
    do begin
      @(posedge ref_clk);
      w = avs_waitrequest;
      q = avs_readdata;
      k++;
    end while (w !== 1'b0 && k < 50);
    if (w !== 1'b0) chk(32'h1, 32'h0, "bus answer");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 8'h00, q);
    chk(q & m, e, "register read");
  endtask

  // Watches n edges: first edge showing a watchdog reset and how long the pin is pulled.
  task automatic watch(input int n);
    at = -1;
    pin = 0;
    for (int i = 1; i <= n; i++) begin
      @(posedge ref_clk);
      if (wd_reset_req === 1'b1 && at < 0) at = i;
      if (rst_pin_oe === 1'b1) pin++;
    end
  endtask

  // A full timeout after a service write must bite once with a 32-cycle pin pulse.
  // The power-up prescaler clear is let pass first, as it would stretch the period.
  task automatic bite();
    repeat (4100) @(posedge ref_clk);
    wr(A_SVC, 8'h00);
    watch(8300);
    chk({31'h0, at >= 8160 && at <= 8178}, 32'h1, "timeout length");
    chk(pin, 32, "pin pulse length");
  endtask

  // A fresh service first, so that a broken disable or freeze would bite inside the window.
  task automatic quiet();
    wr(A_SVC, 8'h00);
    watch(QUIET);
    chk(at, -1, "no watchdog reset");
  endtask

  // Pulses stop or monitor entry and returns grant and illegal-opcode outputs one cycle later.
  task automatic fire(input logic st, input logic mon);
    @(posedge ref_clk);
    stop_exec <= st;
    monitor_entry <= mon;
    @(posedge ref_clk);
    stop_exec <= 1'b0;
    monitor_entry <= 1'b0;
    @(posedge ref_clk);
    o = {stop_grant, illegal_op_reset};
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk(A_CFG, 32'hff, 32'h0);
    rd_chk(A_CAU, 32'h1, 32'h0);
    rd_chk(A_SVC, 32'hffffffff, {24'h0, VEC});
    rd_chk(A_BAD, 32'hffffffff, 32'h0);
    // Short timeout fires even while waiting.
    wait_mode <= 1'b1;
    bite();
    chk({31'h0, rst_pin_o}, 32'h0, "pin drive level");
    rd_chk(A_CAU, 32'h1, 32'h1);
    wr(A_CAU, 8'h01);
    rd_chk(A_CAU, 32'h1, 32'h0);
    wait_mode <= 1'b0;
    // Regular servicing from the main sequence keeps the reset away.
    repeat (2) begin
      wr(A_SVC, 8'hff);
      watch(6000);
      chk(at, -1, "serviced");
    end
    // Long rate outlasts the short period.
    wr(A_CFG, 8'h04);
    rd_chk(A_CFG, 32'hff, 32'h04);
    quiet();
    // Configuration disable suppresses the reset.
    wr(A_CFG, 8'h01);
    rd_chk(A_STA, 32'h1, 32'h1);
    quiet();
    // Stop allowed: granted, then stop mode freezes the count.
    wr(A_CFG, 8'h02);
    fire(1'b1, 1'b0);
    chk({30'h0, o}, 32'h2, "stop granted");
    stop_mode <= 1'b1;
    quiet();
    stop_mode <= 1'b0;
    wr(A_CFG, 8'h00);
    fire(1'b1, 1'b0);
    chk({30'h0, o}, 32'h1, "stop refused");
    // Monitor entry with test voltage on the interrupt pin, voltage kept on the reset pin.
    hv_irq <= 1'b1;
    hv_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    fire(1'b0, 1'b1);
    hv_irq <= 1'b0;
    quiet();
    hv_rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd_chk(A_STA, 32'h1, 32'h0);
    // Break with test voltage on the reset pin.
    break_active <= 1'b1;
    hv_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd_chk(A_STA, 32'h1, 32'h1);
    quiet();
    break_active <= 1'b0;
    hv_rst <= 1'b0;
    // Blank-vector monitor entry holds until power-on reset only.
    fire(1'b0, 1'b1);
    quiet();
    rd_chk(A_STA, 32'h1, 32'h1);
    rstn <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    bite();
    finish_test();
  end
endmodule
